// ### include/tcc_pkg.sv
// Shared constants of the timer channel block
package tcc_pkg;

    // Bus and datapath widths, channel and pair counts
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 8;
    localparam int CNT_W    = 16;
    localparam int NUM_CH   = 6;
    localparam int NUM_PAIR = 3;

    // Register offsets of the timer-wide group
    localparam logic [7:0] A_TIMER_CTRL  = 8'h00;
    localparam logic [7:0] A_COUNT_HIGH  = 8'h01;
    localparam logic [7:0] A_COUNT_LOW   = 8'h02;
    localparam logic [7:0] A_MODULO_HIGH = 8'h03;
    localparam logic [7:0] A_MODULO_LOW  = 8'h04;

    // Channel group: control, value high byte, value low byte per channel
    localparam int CH_BASE   = 5;
    localparam int CH_STRIDE = 3;
    localparam int K_CTRL    = 0;
    localparam int K_HIGH    = 1;
    localparam int K_LOW     = 2;

    // Timer control field positions
    localparam int TC_WRAP_FLAG = 7;
    localparam int TC_HALT      = 5;
    localparam int TC_CLEAR     = 4;

    // Channel control field positions
    localparam int CC_FLAG     = 7;
    localparam int CC_IRQ_EN   = 6;
    localparam int CC_BUF_SEL  = 5;
    localparam int CC_UNBUF    = 4;
    localparam int CC_ELS_HIGH = 3;
    localparam int CC_ELS_LOW  = 2;
    localparam int CC_TOGGLE   = 1;
    localparam int CC_FULL     = 0;

    // Writable bits of even and odd channel control registers
    localparam logic [7:0] CC_MASK_EVEN = 8'h7F;
    localparam logic [7:0] CC_MASK_ODD  = 8'h5F;

    // Reset values
    localparam logic [7:0]  CC_RESET     = 8'h00;
    localparam logic [15:0] VAL_RESET    = 16'h0000;
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [15:0] MODULO_RESET = 16'hFFFF;
    localparam logic        HALT_RESET   = 1'b1;

    // Edge/level select codes
    localparam logic [1:0] ELS_OFF  = 2'b00;
    localparam logic [1:0] ELS_LOW  = 2'b01;
    localparam logic [1:0] ELS_HIGH = 2'b10;
    localparam logic [1:0] ELS_BOTH = 2'b11;

endpackage

// ### src/tcc_chan_core.sv
`timescale 1ns/1ps
// Pin-side logic of one channel: edge detection, compare match and output level
module tcc_chan_core (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        active,
    input  wire logic        mode_unbuf,
    input  wire logic        mode_buf,
    input  wire logic [1:0]  els,
    input  wire logic        toggle_on_wrap,
    input  wire logic        full_duty_force,
    input  wire logic        running,
    input  wire logic        wrap,
    input  wire logic [15:0] count,
    input  wire logic [15:0] compare_value,
    input  wire logic        capture_block,
    input  wire logic        compare_block,
    input  wire logic        pin_in,
    output logic             capture_evt,
    output logic             compare_evt,
    output logic             pin_out,
    output logic             pin_oe_n
);

    typedef struct packed {
        logic pin_prev;
        logic out_lvl;
        logic full_eff;
    } tcc_core_state_t;

    tcc_core_state_t s_q;
    tcc_core_state_t s_d;

    logic connected;
    logic cap_mode;
    logic cmp_mode;
    logic rise;
    logic fall;
    logic pwm_clear;

    // Mode decode shared by events and pin
    // pin released when off
    assign connected = active && (els != tcc_pkg::ELS_OFF);
    assign cap_mode  = !mode_buf && !mode_unbuf;
    assign cmp_mode  = mode_buf || mode_unbuf;
    assign rise      = pin_in && !s_q.pin_prev;
    assign fall      = !pin_in && s_q.pin_prev;
    assign pwm_clear = toggle_on_wrap && (els == tcc_pkg::ELS_HIGH);

    // Capture trigger; halted counter or high-byte read holds it off
    always_comb begin
        capture_evt = 1'b0;
        if (connected && cap_mode && running && !capture_block) begin
            case (els)
                tcc_pkg::ELS_LOW:  capture_evt = rise;
                tcc_pkg::ELS_HIGH: capture_evt = fall;
                tcc_pkg::ELS_BOTH: capture_evt = rise || fall;
                default:           capture_evt = 1'b0;
            endcase
        end
    end

    assign compare_evt = active && cmp_mode && running && !compare_block && (count == compare_value);

    // Next pin level
    always_comb begin
        s_d          = s_q;
        s_d.pin_prev = pin_in;
        if (wrap) begin
            s_d.full_eff = full_duty_force;
        end
        if (!connected) begin
            s_d.out_lvl = !mode_unbuf;
        end else if (cmp_mode) begin
            if (wrap && toggle_on_wrap) begin
                s_d.out_lvl = pwm_clear ? 1'b1 : !s_q.out_lvl;
            end else if (compare_evt) begin
                case (els)
                    tcc_pkg::ELS_LOW:  s_d.out_lvl = !s_q.out_lvl;
                    tcc_pkg::ELS_HIGH: s_d.out_lvl = (s_q.full_eff && pwm_clear) ? 1'b1 : 1'b0;
                    tcc_pkg::ELS_BOTH: s_d.out_lvl = 1'b1;
                    default:           s_d.out_lvl = s_q.out_lvl;
                endcase
            end
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Driven only in a connected compare mode
    assign pin_out  = s_q.out_lvl;
    assign pin_oe_n = !(connected && cmp_mode);

endmodule // tcc_chan_core

// ### src/tcc_timer_channels.sv
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module tcc_timer_channels (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [5:0]  chan_pin_in,
    output logic      [5:0]  chan_pin_out,
    output logic      [5:0]  chan_pin_oe_n,
    output logic      [5:0]  chan_irq_req,
    output logic      [15:0] counter_value,
    output logic             counter_wrap_flag
);

    typedef struct packed {
        logic [5:0][7:0]  ctrl;
        logic [5:0][15:0] val;
        logic [5:0]       armed;
        logic [5:0]       cap_blk;
        logic [5:0]       cmp_blk;
        logic [2:0]       pair_sel;
        logic [2:0]       pair_pend;
        logic [15:0]      cnt;
        logic [15:0]      modv;
        logic             halt;
        logic             wrap_flag;
        logic             wrap_armed;
        logic [7:0]       rdata;
    } tcc_state_t;

    tcc_state_t s_q;
    tcc_state_t s_d;

    logic        running;
    logic        wrap;
    logic [5:0]  chan_active;
    logic [5:0]  cap_evt;
    logic [5:0]  cmp_evt;
    logic [5:0]  evt;
    logic [5:0][15:0] cmp_val;
    logic [5:0]  cmp_blk_eff;

    // Byte address of one register of one channel
    function automatic logic [7:0] chan_addr(input int ch, input int kind);
        chan_addr = 8'(tcc_pkg::CH_BASE + ch * tcc_pkg::CH_STRIDE + kind);
    endfunction

    // Channel is buffered-paired when its even partner has buffered mode set
    function automatic logic odd_disabled(input tcc_state_t st, input int ch);
        odd_disabled = (ch % 2 == 1) && st.ctrl[(ch / 2) * 2][tcc_pkg::CC_BUF_SEL];
    endfunction

    // Compare modes: buffered or unbuffered selected
    function automatic logic in_cmp_mode(input logic [7:0] c);
        in_cmp_mode = c[tcc_pkg::CC_BUF_SEL] || c[tcc_pkg::CC_UNBUF];
    endfunction

    assign running = !s_q.halt;
    assign wrap    = running && (s_q.cnt == s_q.modv);

    // Per-channel enable and compare source
    always_comb begin
        for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
            chan_active[ch] = !odd_disabled(s_q, ch);
            cmp_val[ch]     = s_q.val[ch];
            cmp_blk_eff[ch] = s_q.cmp_blk[ch];
        end
        for (int p = 0; p < tcc_pkg::NUM_PAIR; p++) begin
            if (s_q.ctrl[2 * p][tcc_pkg::CC_BUF_SEL]) begin
                cmp_val[2 * p]     = s_q.pair_sel[p] ? s_q.val[2 * p + 1] : s_q.val[2 * p];
                cmp_blk_eff[2 * p] = s_q.cmp_blk[2 * p] || s_q.cmp_blk[2 * p + 1];
            end
        end
    end

    // One pin core per channel
    for (genvar g = 0; g < tcc_pkg::NUM_CH; g++) begin : g_chan
        tcc_chan_core u_core (
            .core_clk        (core_clk),
            .resetn          (resetn),
            .clk_en          (clk_en),
            .active          (chan_active[g]),
            .mode_unbuf      (s_q.ctrl[g][tcc_pkg::CC_UNBUF]),
            .mode_buf        (s_q.ctrl[g][tcc_pkg::CC_BUF_SEL]),
            .els             (s_q.ctrl[g][tcc_pkg::CC_ELS_HIGH:tcc_pkg::CC_ELS_LOW]),
            .toggle_on_wrap  (s_q.ctrl[g][tcc_pkg::CC_TOGGLE]),
            .full_duty_force (s_q.ctrl[g][tcc_pkg::CC_FULL]),
            .running         (running),
            .wrap            (wrap),
            .count           (s_q.cnt),
            .compare_value   (cmp_val[g]),
            .capture_block   (s_q.cap_blk[g]),
            .compare_block   (cmp_blk_eff[g]),
            .pin_in          (chan_pin_in[g]),
            .capture_evt     (cap_evt[g]),
            .compare_evt     (cmp_evt[g]),
            .pin_out         (chan_pin_out[g]),
            .pin_oe_n        (chan_pin_oe_n[g])
        );
    end

    assign evt = cap_evt | cmp_evt;

    // Register file, counter and flags
    always_comb begin
        s_d = s_q;

        // Read port: data stand in the next cycle only
        s_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                tcc_pkg::A_TIMER_CTRL: begin
                    s_d.rdata[tcc_pkg::TC_WRAP_FLAG] = s_q.wrap_flag;
                    s_d.rdata[tcc_pkg::TC_HALT]      = s_q.halt;
                    if (s_q.wrap_flag) begin
                        s_d.wrap_armed = 1'b1;
                    end
                end
                tcc_pkg::A_COUNT_HIGH:  s_d.rdata = s_q.cnt[15:8];
                tcc_pkg::A_COUNT_LOW:   s_d.rdata = s_q.cnt[7:0];
                tcc_pkg::A_MODULO_HIGH: s_d.rdata = s_q.modv[15:8];
                tcc_pkg::A_MODULO_LOW:  s_d.rdata = s_q.modv[7:0];
                default:                s_d.rdata = 8'h00;
            endcase
            for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
                if (reg_addr == chan_addr(ch, tcc_pkg::K_CTRL)) begin
                    // Disabled odd control register reads as zero
                    s_d.rdata = odd_disabled(s_q, ch) ? 8'h00 : s_q.ctrl[ch];
                    if (s_q.ctrl[ch][tcc_pkg::CC_FLAG] && !odd_disabled(s_q, ch)) begin
                        s_d.armed[ch] = 1'b1;
                    end
                end
                if (reg_addr == chan_addr(ch, tcc_pkg::K_HIGH)) begin
                    s_d.rdata = s_q.val[ch][15:8];
                    if (!in_cmp_mode(s_q.ctrl[ch])) begin
                        s_d.cap_blk[ch] = 1'b1;
                    end
                end
                if (reg_addr == chan_addr(ch, tcc_pkg::K_LOW)) begin
                    s_d.rdata       = s_q.val[ch][7:0];
                    s_d.cap_blk[ch] = 1'b0;
                end
            end
        end

        // Counter: clear wins over counting, halt freezes it
        if (!s_q.halt) begin
            s_d.cnt = wrap ? 16'h0000 : s_q.cnt + 16'h0001;
        end

        // Write port
        if (reg_wr) begin
            case (reg_addr)
                tcc_pkg::A_TIMER_CTRL: begin
                    s_d.halt = reg_wdata[tcc_pkg::TC_HALT];
                    if (reg_wdata[tcc_pkg::TC_CLEAR]) begin
                        // clear with halt stops at zero
                        s_d.cnt = tcc_pkg::CNT_RESET;
                    end
                    if (s_q.wrap_armed && !reg_wdata[tcc_pkg::TC_WRAP_FLAG]) begin
                        s_d.wrap_flag = 1'b0;
                    end
                    s_d.wrap_armed = 1'b0;
                end
                tcc_pkg::A_MODULO_HIGH: s_d.modv[15:8] = reg_wdata;
                tcc_pkg::A_MODULO_LOW:  s_d.modv[7:0]  = reg_wdata;
                default: begin
                end
            endcase
            for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
                if (reg_addr == chan_addr(ch, tcc_pkg::K_CTRL) && !odd_disabled(s_q, ch)) begin
                    // buffered bit only on even channels
                    s_d.ctrl[ch] = (reg_wdata & ((ch % 2 == 0) ? tcc_pkg::CC_MASK_EVEN : tcc_pkg::CC_MASK_ODD))
                                 | {s_q.ctrl[ch][tcc_pkg::CC_FLAG], 7'h00};
                    // zero after read clears, one ignored
                    if (s_q.armed[ch] && !reg_wdata[tcc_pkg::CC_FLAG]) begin
                        s_d.ctrl[ch][tcc_pkg::CC_FLAG] = 1'b0;
                    end
                    s_d.armed[ch] = 1'b0;
                end
                if (reg_addr == chan_addr(ch, tcc_pkg::K_HIGH)) begin
                    s_d.val[ch][15:8] = reg_wdata;
                    if (in_cmp_mode(s_q.ctrl[ch]) || odd_disabled(s_q, ch)) begin
                        s_d.cmp_blk[ch] = 1'b1;
                    end
                end
                if (reg_addr == chan_addr(ch, tcc_pkg::K_LOW)) begin
                    s_d.val[ch][7:0] = reg_wdata;
                    s_d.cmp_blk[ch]  = 1'b0;
                end
            end
            // note a new value in the idle register
            for (int p = 0; p < tcc_pkg::NUM_PAIR; p++) begin
                if (s_q.ctrl[2 * p][tcc_pkg::CC_BUF_SEL]) begin
                    if (reg_addr == chan_addr(s_q.pair_sel[p] ? 2 * p : 2 * p + 1, tcc_pkg::K_LOW)) begin
                        s_d.pair_pend[p] = 1'b1;
                    end
                end
            end
        end

        // Wrap flag: set wins over a clear in the same cycle
        if (wrap) begin
            s_d.wrap_flag  = 1'b1;
            s_d.wrap_armed = 1'b0;
        end

        for (int p = 0; p < tcc_pkg::NUM_PAIR; p++) begin
            if (!s_q.ctrl[2 * p][tcc_pkg::CC_BUF_SEL]) begin
                s_d.pair_sel[p]  = 1'b0;
                s_d.pair_pend[p] = 1'b0;
            end else if (wrap && s_q.pair_pend[p]) begin
                s_d.pair_sel[p]  = !s_q.pair_sel[p];
                s_d.pair_pend[p] = 1'b0;
            end
        end

        // Channel events last so that a set beats a clear
        for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
            if (evt[ch]) begin
                s_d.ctrl[ch][tcc_pkg::CC_FLAG] = 1'b1;
                s_d.armed[ch] = 1'b0;
            end
            if (cap_evt[ch]) begin
                s_d.val[ch] = s_q.cnt;
            end
        end
    end

    // State register; the clock enable freezes everything
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q            <= '0;
            s_q.ctrl       <= {tcc_pkg::NUM_CH{tcc_pkg::CC_RESET}};
            s_q.val        <= {tcc_pkg::NUM_CH{tcc_pkg::VAL_RESET}};
            s_q.cnt        <= tcc_pkg::CNT_RESET;
            s_q.modv       <= tcc_pkg::MODULO_RESET;
            s_q.halt       <= tcc_pkg::HALT_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Outputs
    always_comb begin
        for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
            chan_irq_req[ch] = s_q.ctrl[ch][tcc_pkg::CC_FLAG] && s_q.ctrl[ch][tcc_pkg::CC_IRQ_EN]
                             && chan_active[ch];
        end
    end

    assign reg_rdata         = s_q.rdata;
    assign counter_value     = s_q.cnt;
    assign counter_wrap_flag = s_q.wrap_flag;

endmodule // tcc_timer_channels

// ### verification/tcc_timer_channels_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the timer channel block
module tcc_timer_channels_asserts (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        clk_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [5:0]  chan_pin_in,
    input wire logic [5:0]  chan_pin_out,
    input wire logic [5:0]  chan_pin_oe_n,
    input wire logic [5:0]  chan_irq_req,
    input wire logic [15:0] counter_value,
    input wire logic        counter_wrap_flag
);
    logic ch0_wr;
    logic tc_wr;
    // One clock domain, so clocking and reset are shared
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Enabled writes to channel 0 control and to the timer control
    assign ch0_wr = clk_en && reg_wr && reg_addr == 8'(tcc_pkg::CH_BASE);
    assign tc_wr  = clk_en && reg_wr && reg_addr == tcc_pkg::A_TIMER_CTRL;
    sequence zero_held;
        (counter_value == 16'h0000) [*2];
    endsequence
    a_rdata_idle_zero: assert property (
        clk_en && !reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero outside a read");
    a_cnt_step: assert property (
        clk_en |=> counter_value == 16'h0000 || counter_value == $past(counter_value)
        || counter_value == $past(counter_value) + 16'h0001) else $error("counter jumped");
    a_wrap_restart: assert property (
        $rose(counter_wrap_flag) |-> counter_value == 16'h0000) else $error("wrap without restart");
    a_halt_clear_zero: assert property (
        tc_wr && reg_wdata[tcc_pkg::TC_HALT] && reg_wdata[tcc_pkg::TC_CLEAR] |=> zero_held)
        else $error("halt with clear did not hold zero");
    a_odd_release: assert property (
        ch0_wr && reg_wdata[tcc_pkg::CC_BUF_SEL] |=> chan_pin_oe_n[1] && !chan_irq_req[1])
        else $error("odd channel still active in buffered pair");
    a_pin_release: assert property (
        ch0_wr && reg_wdata[tcc_pkg::CC_ELS_HIGH -: 2] == 2'b00 |=> chan_pin_oe_n[0])
        else $error("pin still driven with edge bits clear");
    a_irq_gate_off: assert property (
        ch0_wr && !reg_wdata[tcc_pkg::CC_IRQ_EN] |=> !chan_irq_req[0]) else $error("request while disabled");
    a_preset_low: assert property (
        ch0_wr && reg_wdata[tcc_pkg::CC_ELS_HIGH -: 2] == 2'b00 && reg_wdata[tcc_pkg::CC_UNBUF]
        |=> ##1 !chan_pin_out[0]) else $error("preset level not low");
endmodule // tcc_timer_channels_asserts

bind tcc_timer_channels tcc_timer_channels_asserts u_chk (.core_clk(core_clk), .resetn(resetn),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
    .chan_pin_oe_n(chan_pin_oe_n), .chan_irq_req(chan_irq_req), .counter_value(counter_value),
    .counter_wrap_flag(counter_wrap_flag));

// ### verification/tcc_pin_model.sv
`timescale 1ns/1ps
// Far side of the channel pins: outside drivers meet the block's outputs
module tcc_pin_model (
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe_n,
    input  wire logic [5:0] ext_level,
    output logic      [5:0] pin_level
);
    // released pin follows outside
    // A pin the block lets go is owned by the outside driver, never by a stale level
    assign pin_level = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule // tcc_pin_model

// ### verification/testbench.sv
`timescale 1ns/1ps
// Register-level regression of the timer channel block
module testbench;
    logic        core_clk;
    logic        resetn;
    logic        clk_en;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [7:0]  d;
    logic [5:0]  ext_level;
    logic [5:0]  pin_level;
    logic [5:0]  chan_pin_out;
    logic [5:0]  chan_pin_oe_n;
    logic [5:0]  chan_irq_req;
    logic [15:0] counter_value;
    logic [15:0] held;
    logic        counter_wrap_flag;
    int          mismatches;
    int          n_checks;
    int          code;

    // Clock with an 8 ns period
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    tcc_timer_channels dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .chan_pin_in(pin_level), .chan_pin_out(chan_pin_out), .chan_pin_oe_n(chan_pin_oe_n),
        .chan_irq_req(chan_irq_req), .counter_value(counter_value), .counter_wrap_flag(counter_wrap_flag));
    tcc_pin_model pins (.pin_out(chan_pin_out), .pin_oe_n(chan_pin_oe_n), .ext_level(ext_level),
        .pin_level(pin_level));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [7:0] ch(input int n, input int k);
        return 8'(tcc_pkg::CH_BASE + tcc_pkg::CH_STRIDE * n + k);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data only stands in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        check(v, e);
    endtask
    // Bounded wait for a counter value, sampled after the edge settles
    task automatic wait_cnt(input logic [15:0] v);
        for (int i = 0; i < 64; i++) begin
            @(posedge core_clk);
            #1;
            if (counter_value === v) break;
        end
        check(counter_value, v);
    endtask
    task automatic pin_edge(input logic v);
        @(posedge core_clk);
        ext_level[2] <= v;
        repeat (3) @(posedge core_clk);
    endtask

    initial begin
        #200us;
        mismatches++;
        end_sim();
    end

    initial begin
        {resetn, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {clk_en, ext_level, mismatches, n_checks} = {7'h7F, 32'd0, 32'd0};
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        for (code = 0; code < 6; code++) rdc(ch(code, 0), 8'h00);
        rdc(tcc_pkg::A_TIMER_CTRL, 8'h20);
        rdc(8'hFF, 8'h00);
        // pairing of channel 0 and 1
        wr(ch(1, 0), 8'h34);
        rdc(ch(1, 0), 8'h14);
        check(chan_pin_oe_n[1], 1'b0);
        wr(ch(0, 0), 8'h24);
        rdc(ch(1, 0), 8'h00);
        check(chan_pin_oe_n[1], 1'b1);
        wr(tcc_pkg::A_MODULO_HIGH, 8'h00);
        wr(tcc_pkg::A_MODULO_LOW, 8'h09);
        for (code = 1; code < 4; code++) begin
            wr(tcc_pkg::A_TIMER_CTRL, 8'h30);
            wr(ch(0, 0), 8'h10);
            repeat (2) @(posedge core_clk);
            #1 check(chan_pin_out[0], 1'b0);
            wr(ch(0, 0), 8'h50 | 8'(code << 2));
            wr(ch(0, 1), 8'h00);
            wr(ch(0, 2), 8'h05);
            wr(tcc_pkg::A_TIMER_CTRL, 8'h00);
            wait_cnt(16'h0007);
            check({chan_pin_oe_n[0], chan_pin_out[0]}, {1'b0, code != 2});
            check(chan_irq_req[0], 1'b1);
            wr(tcc_pkg::A_TIMER_CTRL, 8'h20);
            wr(ch(0, 0), 8'h50 | 8'(code << 2));
            rdc(ch(0, 0), 8'hD0 | 8'(code << 2));
            wr(ch(0, 0), 8'h50 | 8'(code << 2));
            rdc(ch(0, 0), 8'h50 | 8'(code << 2));
            check(chan_irq_req[0], 1'b0);
            wr(ch(0, 0), 8'hD0 | 8'(code << 2));
            rdc(ch(0, 0), 8'h50 | 8'(code << 2));
        end
        // a match between read and write keeps the flag
        wr(tcc_pkg::A_TIMER_CTRL, 8'h00);
        wait_cnt(16'h0007);
        rd(ch(0, 0), d);
        wait_cnt(16'h0007);
        wr(ch(0, 0), 8'h5C);
        rdc(ch(0, 0), 8'hDC);
        // high byte write holds off matches until the low byte
        wr(ch(0, 1), 8'h00);
        rd(ch(0, 0), d);
        wr(ch(0, 0), 8'h5C);
        wait_cnt(16'h0007);
        rdc(ch(0, 0), 8'h5C);
        wr(ch(0, 2), 8'h05);
        wait_cnt(16'h0007);
        rdc(ch(0, 0), 8'hDC);
        for (code = 1; code < 4; code++) begin
            wr(ch(2, 0), 8'(code << 2));
            rd(ch(2, 0), d);
            wr(ch(2, 0), 8'(code << 2));
            pin_edge(1'b0);
            rdc(ch(2, 0), (code != 1 ? 8'h80 : 8'h00) | 8'(code << 2));
            rd(ch(2, 0), d);
            wr(ch(2, 0), 8'(code << 2));
            pin_edge(1'b1);
            rdc(ch(2, 0), (code != 2 ? 8'h80 : 8'h00) | 8'(code << 2));
        end
        // high byte read holds off captures
        wr(ch(2, 0), 8'h0C);
        rdc(ch(2, 1), 8'h00);
        pin_edge(1'b0);
        rdc(ch(2, 0), 8'h0C);
        rd(ch(2, 2), d);
        pin_edge(1'b1);
        rdc(ch(2, 0), 8'h8C);
        // PWM with forced full duty on channel 4
        wr(tcc_pkg::A_TIMER_CTRL, 8'h30);
        // Wrap flag seen on the port, then cleared in two steps while halted
        rdc(tcc_pkg::A_TIMER_CTRL, 8'hA0);
        check(counter_wrap_flag, 1'b1);
        wr(tcc_pkg::A_TIMER_CTRL, 8'h30);
        rdc(tcc_pkg::A_TIMER_CTRL, 8'h20);
        check(counter_wrap_flag, 1'b0);
        wr(ch(4, 0), 8'h1A);
        wr(ch(4, 2), 8'h04);
        wr(tcc_pkg::A_TIMER_CTRL, 8'h00);
        wait_cnt(16'h0000);
        wait_cnt(16'h0006);
        check(chan_pin_out[4], 1'b0);
        wait_cnt(16'h0001);
        check(chan_pin_out[4], 1'b1);
        wr(ch(4, 0), 8'h1B);
        wait_cnt(16'h0006);
        check(chan_pin_out[4], 1'b0);
        wait_cnt(16'h0006);
        check(chan_pin_out[4], 1'b1);
        // Clock enable low freezes the counter
        @(posedge core_clk);
        clk_en <= 1'b0;
        #1 held = counter_value;
        repeat (4) @(posedge core_clk);
        #1 check(counter_value, held);
        clk_en <= 1'b1;
        end_sim();
    end
endmodule // testbench
